// *** sim/host_link_model.sv ***
module host_link_model (
   // link pins
   output logic      sck,
   output logic      xce_n,
   output logic      sdi_in,
   input  wire logic sdo,
   input  wire logic sda_out,
   input  wire logic sda_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 300;
   logic       sda_drv;
   logic       ack_seen;
   logic [7:0] rx [0:7];

   // wired-and of host and device on the shared data pin
   assign sdi_in = sda_drv & (sda_oe_n | sda_out);

   initial begin
      sck = 1'b0;
      xce_n = 1'b1;
      sda_drv = 1'b1;
   end

   ////////////////////////////////////////
   // byte 0 sits in tx[7:0]; a pause after each byte lets writes cross to clk_sys
   task automatic frame(input logic [63:0] tx, input int n_bits);
      xce_n = 1'b0;
      #30;
      for (int i = 0; i < n_bits; i++) begin
         sda_drv = tx[i];
         #6;
         rx[i/8][i%8] = sdo;
         sck = 1'b1;
         #6;
         sck = 1'b0;
         if (i % 8 == 7) #200;
      end
      #30;
      xce_n = 1'b1;
      sda_drv = ~sda_drv;
      #200;
   endtask : frame

   task automatic i2c_bit(input logic b, output logic seen);
      sda_drv = b;
      #T;
      sck = 1'b1;
      #T;
      seen = sdi_in;
      sck = 1'b0;
      #T;
   endtask : i2c_bit

   // select stays high for the whole two-wire transfer
   task automatic i2c_write(input logic [39:0] tx, input int n_bytes);
      logic s;
      sck = 1'b1;
      sda_drv = 1'b1;
      #T;
      sda_drv = 1'b0;
      #T;
      sck = 1'b0;
      ack_seen = 1'b1;
      for (int b = 0; b < n_bytes && ack_seen; b++) begin
         for (int i = 7; i >= 0; i--) i2c_bit(tx[8*b+i], s);
         i2c_bit(1'b1, s);
         ack_seen = !s;
      end
      sda_drv = 1'b0;
      #T;
      sck = 1'b1;
      #T;
      sda_drv = 1'b1;
      #T;
   endtask : i2c_write

   // one byte from the current index; the host answers with a nack and stops
   task automatic i2c_read(input logic [7:0] dev, output logic [7:0] data);
      logic s;
      sck = 1'b1;
      sda_drv = 1'b1;
      #T;
      sda_drv = 1'b0;
      #T;
      sck = 1'b0;
      for (int i = 7; i >= 0; i--) i2c_bit(dev[i], s);
      i2c_bit(1'b1, s);
      ack_seen = !s;
      for (int i = 7; i >= 0; i--) i2c_bit(1'b1, data[i]);
      i2c_bit(1'b1, s);
      sda_drv = 1'b0;
      #T;
      sck = 1'b1;
      #T;
      sda_drv = 1'b1;
      #T;
   endtask : i2c_read
endmodule : host_link_model

// *** sim/sensor_serial_port_monitor.sv ***
module sensor_serial_port_monitor (
   // system
   input wire logic       clk_sys,
   input wire logic       reset_n,
   // pins
   input wire logic       xce_n,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       sdo_oe_n,
   // core side
   input wire logic [7:0] core_page,
   input wire logic [7:0] core_data,
   input wire logic [1:0] proto_mode
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence lock_two_wire;
      $changed(proto_mode) ##0 proto_mode == 2'h2;
   endsequence

   sequence lock_four_wire;
      $changed(proto_mode) ##0 proto_mode == 2'h1;
   endsequence

   ////////////////////////////////////////
   a_sdo_follows_select: assert property (sdo_oe_n == xce_n)
      else $error("sdo enable differs from select");
   a_mode_held_locked: assert property (proto_mode != 2'h0 |=> $stable(proto_mode))
      else $error("protocol mode changed after lock");
   a_mode_code_legal: assert property (proto_mode != 2'h3)
      else $error("protocol mode code unused value");
   a_two_wire_lock: assert property (lock_two_wire |-> xce_n)
      else $error("two-wire lock while select low");
   a_four_wire_lock: assert property (lock_four_wire |-> !xce_n)
      else $error("four-wire lock while select high");
   a_four_wire_quiet: assert property (proto_mode == 2'h1 |-> sda_oe_n)
      else $error("sda driven in four-wire mode");
   a_ack_needs_mode: assert property (!sda_oe_n |-> proto_mode == 2'h2 && sda_out == 1'b0)
      else $error("sda driven outside two-wire mode");
   a_bad_page_zero: assert property (!(core_page inside {[8'h02:8'h06]}) |=> core_data == 8'h00)
      else $error("core data nonzero for invalid page");
endmodule : sensor_serial_port_monitor

bind sensor_register_serial_port sensor_serial_port_monitor sensor_serial_port_monitor_inst (
   .clk_sys(clk_sys), .reset_n(reset_n), .xce_n(xce_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .sdo_oe_n(sdo_oe_n), .core_page(core_page), .core_data(core_data), .proto_mode(proto_mode));

// *** sim/testbench.sv ***
`include "sensor_serial_map.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys, reset_n, sck, xce_n, sdi_in, sda_out, sda_oe_n, sdo, sdo_oe_n, frame_reflect;
   logic [7:0] core_page, core_addr, core_data;
   logic [1:0] proto_mode;
   int         n_mismatch, comparisons;

   always #12.5 clk_sys = ~clk_sys;

   sensor_register_serial_port #(.FRAME_PAGES(`SRSP_FRAME_PAGES)) sensor_register_serial_port_inst (
      .clk_sys(clk_sys), .reset_n(reset_n), .sck(sck), .xce_n(xce_n), .sdi_in(sdi_in),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
      .frame_reflect(frame_reflect), .core_page(core_page), .core_addr(core_addr),
      .core_data(core_data), .proto_mode(proto_mode));

   host_link_model host_link_model_inst (.sck(sck), .xce_n(xce_n), .sdi_in(sdi_in), .sdo(sdo),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n));

   ////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask : check

   task automatic peek(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clk_sys);
      core_page = page;
      core_addr = addr;
      repeat (2) @(negedge clk_sys);
      check("core_data", exp, core_data);
   endtask : peek

   task automatic do_reset;
      @(negedge clk_sys);
      reset_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
   endtask : do_reset

   task automatic complete_run;
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////
   task automatic test_write_readback;
      check("proto_mode", 8'h00, {6'h00, proto_mode});
      host_link_model_inst.frame({8'h3C, 8'hA5, 8'h10, 8'h02}, 32);
      check("old byte", 8'h00, host_link_model_inst.rx[2]);
      peek(8'h02, 8'h10, 8'hA5);
      peek(8'h02, 8'h11, 8'h3C);
      host_link_model_inst.frame({8'h5A, 8'h10, 8'h02}, 24);
      check("old byte", 8'hA5, host_link_model_inst.rx[2]);
      check("proto_mode", 8'h01, {6'h00, proto_mode});
      host_link_model_inst.frame({16'h0000, 8'h10, 8'h82}, 32);
      check("read byte", 8'h5A, host_link_model_inst.rx[2]);
      check("read byte", 8'h3C, host_link_model_inst.rx[3]);
      peek(8'h02, 8'h10, 8'h5A);
      peek(8'h82, 8'h10, 8'h00);
   endtask : test_write_readback

   // frame-class pages stay unapplied until the reflection pulse
   task automatic test_pages;
      logic [7:0] v;
      for (int p = 2; p <= 6; p++) begin
         v = 8'(p * 17);
         host_link_model_inst.frame({v, 8'h20, 8'(p)}, 24);
         peek(8'(p), 8'h20, `SRSP_FRAME_PAGES >> (p - 2) & 1 ? 8'h00 : v);
         @(negedge clk_sys) frame_reflect = 1'b1;
         repeat (4) @(negedge clk_sys);
         frame_reflect = 1'b0;
         peek(8'(p), 8'h20, v);
         host_link_model_inst.frame({8'h00, 8'h20, 8'(p) | 8'h80}, 24);
         check("read byte", v, host_link_model_inst.rx[2]);
      end
   endtask : test_pages

   task automatic test_bad_codes;
      logic [7:0] codes [0:4] = '{8'h00, 8'h01, 8'h07, 8'h81, 8'h87};
      foreach (codes[i]) begin
         host_link_model_inst.frame({8'hFF, 8'h20, codes[i]}, 24);
         check("refused byte", 8'h00, host_link_model_inst.rx[2]);
         peek(8'h02, 8'h20, 8'h22);
      end
      host_link_model_inst.frame({8'hFF, 8'h30, 8'h02}, 21);
      peek(8'h02, 8'h30, 8'h00);
   endtask : test_bad_codes

   task automatic test_two_wire;
      logic [7:0] d;
      do_reset;
      host_link_model_inst.i2c_write({8'h7E, 8'hC3, 8'h40, 8'h02, 8'h34}, 5);
      check("ack", 8'h01, {7'h00, host_link_model_inst.ack_seen});
      peek(8'h02, 8'h40, 8'hC3);
      peek(8'h02, 8'h41, 8'h7E);
      check("proto_mode", 8'h02, {6'h00, proto_mode});
      host_link_model_inst.i2c_write({8'h40, 8'h02, 8'h34}, 3);
      host_link_model_inst.i2c_read(8'h35, d);
      check("i2c read", 8'hC3, d);
      check("ack", 8'h01, {7'h00, host_link_model_inst.ack_seen});
      host_link_model_inst.i2c_read(8'h35, d);
      check("i2c read", 8'h7E, d);
      host_link_model_inst.i2c_write({8'h55, 8'h40, 8'h02, 8'h36}, 4);
      check("ack", 8'h00, {7'h00, host_link_model_inst.ack_seen});
      peek(8'h02, 8'h40, 8'hC3);
      host_link_model_inst.frame({8'h99, 8'h42, 8'h02}, 24);
      peek(8'h02, 8'h42, 8'h00);
   endtask : test_two_wire

   ////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      frame_reflect = 1'b0;
      core_page = 8'h00;
      core_addr = 8'h00;
      n_mismatch = 0;
      comparisons = 0;
      repeat (6) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      test_write_readback();
      test_pages();
      test_bad_codes();
      test_two_wire();
      complete_run();
   end

   // whole run is about 140 us; the limit leaves ample margin
   initial begin
      #1000000;
      n_mismatch++;
      complete_run();
   end
endmodule : testbench

// *** src/sensor_register_serial_port.sv ***
`include "sensor_serial_map.svh"

module sensor_register_serial_port #(
   parameter logic [4:0] FRAME_PAGES = `SRSP_FRAME_PAGES
) (
   // system
   input  wire  logic       clk_sys,
   input  wire  logic       reset_n,
   // shared serial pins
   input  wire  logic       sck,
   input  wire  logic       xce_n,
   input  wire  logic       sdi_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   output logic             sdo,
   output logic             sdo_oe_n,
   // frame timing
   input  wire  logic       frame_reflect,
   // applied register read port for the sensor core
   input  wire  logic [7:0] core_page,
   input  wire  logic [7:0] core_addr,
   output logic       [7:0] core_data,
   // status
   output logic       [1:0] proto_mode
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic page_ok(input logic [7:0] code);
      page_ok = ((code & `SRSP_CODE_ZERO_MASK) == 8'h00) &&
                (code[2:0] >= `SRSP_PAGE_FIRST) && (code[2:0] <= `SRSP_PAGE_LAST);
   endfunction : page_ok

   function automatic logic [`SRSP_IDX_W-1:0] mem_index(input logic [7:0] page, input logic [7:0] addr);
      logic [2:0] slot;
      slot      = page[2:0] - 3'h2;
      mem_index = {slot, addr};
   endfunction : mem_index

   // register contents as seen by the host, and as applied to the sensor core
   logic [7:0] cfg_mem     [`SRSP_MEM_DEPTH];
   logic [7:0] applied_mem [`SRSP_MEM_DEPTH];

   sensor_serial_pkg::proto_mode_type mode_reg;

   ////////////////////////////////////////////////////////////////////////////
   // four-wire link, on the serial clock; held clear while select is high

   logic       link_clr;
   logic [2:0] lbit_reg;
   logic [1:0] lbyte_reg;
   logic [7:0] lshift_reg;
   logic [7:0] lpage_reg;
   logic       lvalid_reg;
   logic       lread_reg;
   logic [7:0] laddr_reg;
   logic [7:0] lout_reg;
   logic [7:0] byte_in;
   logic [7:0] addr_inc;
   logic       byte_done;

   assign link_clr  = xce_n | ~reset_n;
   assign byte_in   = {sdi_in, lshift_reg[7:1]};
   assign addr_inc  = laddr_reg + 8'h01;
   assign byte_done = (lbit_reg == 3'h7);

   // cfg_mem is read across domains here: while the four-wire link is locked
   // only this link writes it, and never the entry being fetched
   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         lbit_reg   <= 3'h0;
         lbyte_reg  <= 2'h0;
         lshift_reg <= 8'h00;
         lpage_reg  <= 8'h00;
         lvalid_reg <= 1'b0;
         lread_reg  <= 1'b0;
         laddr_reg  <= 8'h00;
         lout_reg   <= 8'h00;
      end else begin
         lbit_reg   <= lbit_reg + 3'h1;
         lshift_reg <= byte_in;
         if (byte_done) begin
            unique case (lbyte_reg)
               2'h0: begin
                  lpage_reg  <= {1'b0, byte_in[6:0]};
                  lvalid_reg <= page_ok({1'b0, byte_in[6:0]});
                  lread_reg  <= byte_in[`SRSP_READ_BIT];
                  lbyte_reg  <= 2'h1;
               end
               2'h1: begin
                  laddr_reg <= byte_in;
                  lout_reg  <= lvalid_reg ? cfg_mem[mem_index(lpage_reg, byte_in)] : 8'h00;
                  lbyte_reg <= 2'h2;
               end
               default: begin
                  laddr_reg <= addr_inc;
                  lout_reg  <= lvalid_reg ? cfg_mem[mem_index(lpage_reg, addr_inc)] : 8'h00;
               end
            endcase
         end
      end
   end

   // output changes on the falling edge so the host samples a settled bit
   logic sdo_reg;
   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         sdo_reg <= 1'b0;
      end else begin
         sdo_reg <= lout_reg[lbit_reg];
      end
   end

   assign sdo      = sdo_reg;
   assign sdo_oe_n = xce_n;

   // write hand-off: held words plus a toggle; not cleared by select so a
   // select edge never fakes a toggle
   logic                   lwr_tog_reg;
   logic [`SRSP_IDX_W-1:0] lwr_idx_reg;
   logic [7:0]             lwr_data_reg;

   always_ff @(posedge sck or negedge reset_n) begin
      if (!reset_n) begin
         lwr_tog_reg  <= 1'b0;
         lwr_idx_reg  <= '0;
         lwr_data_reg <= 8'h00;
      end else if (!xce_n && byte_done && lbyte_reg == 2'h2 && lvalid_reg && !lread_reg) begin
         lwr_tog_reg  <= ~lwr_tog_reg;
         lwr_idx_reg  <= mem_index(lpage_reg, laddr_reg);
         lwr_data_reg <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers into the system clock

   logic [1:0] tog_sync_reg;
   logic       tog_seen_reg;
   logic [1:0] xce_sync_reg;
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic [1:0] refl_sync_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;
   logic       refl_prev_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tog_sync_reg  <= 2'h0;
         tog_seen_reg  <= 1'b0;
         xce_sync_reg  <= 2'h3;
         scl_sync_reg  <= 2'h3;
         sda_sync_reg  <= 2'h3;
         refl_sync_reg <= 2'h0;
         scl_prev_reg  <= 1'b1;
         sda_prev_reg  <= 1'b1;
         refl_prev_reg <= 1'b0;
      end else begin
         tog_sync_reg  <= {tog_sync_reg[0], lwr_tog_reg};
         tog_seen_reg  <= tog_sync_reg[1];
         xce_sync_reg  <= {xce_sync_reg[0], xce_n};
         scl_sync_reg  <= {scl_sync_reg[0], sck};
         sda_sync_reg  <= {sda_sync_reg[0], sdi_in};
         refl_sync_reg <= {refl_sync_reg[0], frame_reflect};
         scl_prev_reg  <= scl_sync_reg[1];
         sda_prev_reg  <= sda_sync_reg[1];
         refl_prev_reg <= refl_sync_reg[1];
      end
   end

   logic link_wr;
   logic reflect_pulse;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;

   // held words are stable for a full byte time, far longer than the toggle's trip
   assign link_wr       = (tog_sync_reg[1] != tog_seen_reg) && (mode_reg == sensor_serial_pkg::MODE_4WIRE);
   assign reflect_pulse = refl_sync_reg[1] & ~refl_prev_reg;
   assign scl_s         = scl_sync_reg[1];
   assign sda_s         = sda_sync_reg[1];
   assign scl_rise      = scl_s & ~scl_prev_reg;
   assign scl_fall      = ~scl_s & scl_prev_reg;
   assign i2c_start     = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign i2c_stop      = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // protocol lock

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= sensor_serial_pkg::MODE_NONE;
      end else if (mode_reg == sensor_serial_pkg::MODE_NONE) begin
         if (!xce_sync_reg[1]) begin
            mode_reg <= sensor_serial_pkg::MODE_4WIRE;
         end else if (i2c_start) begin
            mode_reg <= sensor_serial_pkg::MODE_I2C;
         end
      end
   end

   assign proto_mode = mode_reg;

   ////////////////////////////////////////////////////////////////////////////
   // two-wire target on the system clock

   sensor_serial_pkg::i2c_state_type i2c_state_reg;
   logic [3:0]  ibit_reg;
   logic [7:0]  ishift_reg;
   logic [7:0]  itx_reg;
   logic [15:0] index_reg;
   logic        drive_reg;
   logic        i2c_live;
   logic        i2c_wr;
   logic [7:0]  i2c_rd_byte;

   assign i2c_live    = (mode_reg != sensor_serial_pkg::MODE_4WIRE) && !i2c_start && !i2c_stop &&
                        (i2c_state_reg != sensor_serial_pkg::I2C_IDLE) &&
                        (i2c_state_reg != sensor_serial_pkg::I2C_IGNORE);
   assign i2c_wr      = i2c_live && scl_fall && (ibit_reg == `SRSP_ACK_SLOT) &&
                        (i2c_state_reg == sensor_serial_pkg::I2C_WRITE) && page_ok(index_reg[15:8]);
   assign i2c_rd_byte = page_ok(index_reg[15:8]) ? cfg_mem[mem_index(index_reg[15:8], index_reg[7:0])] : 8'h00;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         i2c_state_reg <= sensor_serial_pkg::I2C_IDLE;
         ibit_reg      <= 4'h0;
         ishift_reg    <= 8'h00;
         itx_reg       <= 8'h00;
         index_reg     <= 16'h0000;
         drive_reg     <= 1'b0;
      end else if (mode_reg == sensor_serial_pkg::MODE_4WIRE) begin
         i2c_state_reg <= sensor_serial_pkg::I2C_IDLE;
         drive_reg     <= 1'b0;
      end else if (i2c_start) begin
         i2c_state_reg <= sensor_serial_pkg::I2C_DEVADDR;
         ibit_reg      <= 4'h0;
         drive_reg     <= 1'b0;
      end else if (i2c_stop) begin
         i2c_state_reg <= sensor_serial_pkg::I2C_IDLE;
         drive_reg     <= 1'b0;
      end else if (i2c_live && scl_rise) begin
         ibit_reg <= ibit_reg + 4'h1;
         if (ibit_reg < `SRSP_ACK_SLOT) begin
            ishift_reg <= {ishift_reg[6:0], sda_s};
         end else if (i2c_state_reg == sensor_serial_pkg::I2C_READ && !drive_reg) begin
            // host's answer slot: index moves on ack or nack alike
            index_reg <= index_reg + 16'h0001;
            if (sda_s) begin
               i2c_state_reg <= sensor_serial_pkg::I2C_IGNORE;
            end
         end
      end else if (i2c_live && scl_fall) begin
         if (ibit_reg == `SRSP_ACK_SLOT) begin
            drive_reg <= 1'b1;
            unique case (i2c_state_reg)
               sensor_serial_pkg::I2C_DEVADDR: begin
                  if (ishift_reg[7:1] == `SRSP_I2C_TARGET) begin
                     i2c_state_reg <= ishift_reg[0] ? sensor_serial_pkg::I2C_READ
                                                    : sensor_serial_pkg::I2C_REGHI;
                  end else begin
                     i2c_state_reg <= sensor_serial_pkg::I2C_IGNORE;
                     drive_reg     <= 1'b0;
                  end
               end
               sensor_serial_pkg::I2C_REGHI: begin
                  index_reg[15:8] <= ishift_reg;
                  i2c_state_reg   <= sensor_serial_pkg::I2C_REGLO;
               end
               sensor_serial_pkg::I2C_REGLO: begin
                  index_reg[7:0] <= ishift_reg;
                  i2c_state_reg  <= sensor_serial_pkg::I2C_WRITE;
               end
               sensor_serial_pkg::I2C_WRITE: begin
                  index_reg <= index_reg + 16'h0001;
               end
               default: begin
                  drive_reg <= 1'b0;
               end
            endcase
         end else if (ibit_reg == `SRSP_AFTER_ACK) begin
            ibit_reg <= 4'h0;
            if (i2c_state_reg == sensor_serial_pkg::I2C_READ) begin
               itx_reg   <= i2c_rd_byte;
               drive_reg <= ~i2c_rd_byte[7];
            end else begin
               drive_reg <= 1'b0;
            end
         end else if (i2c_state_reg == sensor_serial_pkg::I2C_READ) begin
            itx_reg   <= {itx_reg[6:0], 1'b0};
            drive_reg <= ~itx_reg[6];
         end
      end
   end

   // open drain: the pin is only ever pulled low
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~drive_reg;

   ////////////////////////////////////////////////////////////////////////////
   // register storage and application

   logic                   wr_en;
   logic [`SRSP_IDX_W-1:0] wr_idx;
   logic [7:0]             wr_data;

   // the lock guarantees at most one source writes at a time
   assign wr_en   = link_wr | i2c_wr;
   assign wr_idx  = link_wr ? lwr_idx_reg : mem_index(index_reg[15:8], index_reg[7:0]);
   assign wr_data = link_wr ? lwr_data_reg : ishift_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `SRSP_MEM_DEPTH; i++) begin
            cfg_mem[i] <= 8'h00;
         end
      end else if (wr_en) begin
         cfg_mem[wr_idx] <= wr_data;
      end
   end

   // frame-class pages copy over at the reflection point; a write landing in
   // the same cycle to an immediate page still wins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `SRSP_MEM_DEPTH; i++) begin
            applied_mem[i] <= 8'h00;
         end
      end else begin
         if (reflect_pulse) begin
            for (int i = 0; i < `SRSP_MEM_DEPTH; i++) begin
               if (FRAME_PAGES[i >> 8]) begin
                  applied_mem[i] <= cfg_mem[i];
               end
            end
         end
         if (wr_en && !FRAME_PAGES[wr_idx[10:8]]) begin
            applied_mem[wr_idx] <= wr_data;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         core_data <= 8'h00;
      end else begin
         core_data <= page_ok(core_page) ? applied_mem[mem_index(core_page, core_addr)] : 8'h00;
      end
   end

endmodule : sensor_register_serial_port

// *** src/sensor_serial_map.svh ***
`ifndef SENSOR_SERIAL_MAP_SVH
`define SENSOR_SERIAL_MAP_SVH

// page selector codes: write 02h..06h, read adds bit 7
`define SRSP_PAGE_FIRST     8'h02
`define SRSP_PAGE_LAST      8'h06
`define SRSP_READ_BIT       7
`define SRSP_CODE_ZERO_MASK 8'hF8

// two-wire target address, 7 bits
`define SRSP_I2C_TARGET     7'h1A

// register storage
`define SRSP_NUM_PAGES      5
`define SRSP_REGS_PER_PAGE  256
`define SRSP_MEM_DEPTH      1280
`define SRSP_IDX_W          11

// pages applied at the frame reflection point, one bit per page 02h..06h
`define SRSP_FRAME_PAGES    5'h06

// two-wire bit counter marks
`define SRSP_ACK_SLOT       4'h8
`define SRSP_AFTER_ACK      4'h9

`endif

// *** src/sensor_serial_pkg.sv ***
package sensor_serial_pkg;

   // protocol chosen by the first transaction after reset
   typedef enum logic [1:0] {
      MODE_NONE,
      MODE_4WIRE,
      MODE_I2C
   } proto_mode_type;

   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_DEVADDR,
      I2C_REGHI,
      I2C_REGLO,
      I2C_WRITE,
      I2C_READ,
      I2C_IGNORE
   } i2c_state_type;

endpackage : sensor_serial_pkg
